// [video_refresh_consts.svh]
`ifndef VIDEO_REFRESH_CONSTS_SVH
`define VIDEO_REFRESH_CONSTS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_HTOTAL    5'h00
`define IDX_VTOTAL    5'h04
`define IDX_VDISP     5'h06
`define IDX_VSYNC     5'h07
`define IDX_MODE      5'h08
`define IDX_CURSTART  5'h0A
`define IDX_CUREND    5'h0B
`define IDX_CURPOS_HI 5'h0E
`define IDX_CURPOS_LO 5'h0F
`define IDX_UPD_HI    5'h12
`define IDX_UPD_LO    5'h13
`define IDX_STATUS    5'h1E
`define IDX_TRIGGER   5'h1F

// ==========================================================
// Mode control fields
`define MC_ILACE      0
`define MC_VIDEO      1
`define MC_ROWCOL     2
`define MC_TRANSP     3
`define MC_CURSKEW    5
`define MC_STROBE     6
`define MC_INTERLEAVE 7
`define MC_RESET      8'h00

// ==========================================================
// Cursor start fields and blink
`define CS_MODE_HI    6
`define CS_MODE_LO    5
`define CMODE_STEADY  2'h0
`define CMODE_OFF     2'h1
`define CMODE_BLINK16 2'h2
`define BLINK16_BIT   3
`define BLINK32_BIT   4

// ==========================================================
// Status fields
`define ST_READY      7
`define ST_VRETRACE   5

`endif

// [video_refresh_pkg.sv]
package video_refresh_pkg;

  // ========================================================
  // Update sequencer states
  typedef enum logic [2:0] {
    UPD_IDLE  = 3'h1,
    UPD_WAIT  = 3'h2,
    UPD_DRIVE = 3'h4
  } upd_state_t;

  // ========================================================
  // Timing chain inputs, same clock domain
  typedef struct packed {
    logic [13:0] scanLinear;
    logic [7:0]  scanColumn;
    logic [5:0]  scanRow;
    logic [4:0]  rasterLine;
    logic        charTick;
    logic        fieldStart;
    logic        retrace;
    logic        vRetrace;
  } scan_in_t;

  // ========================================================
  // Refresh memory side outputs
  typedef struct packed {
    logic [13:0] refreshAddr;
    logic [4:0]  rasterAddr;
    logic        sharedPin;
    logic        updStrobe;
    logic        cursor;
    logic        oddField;
    logic        phi1;
  } refresh_out_t;

  // ========================================================
  // Whole module state
  typedef struct packed {
    logic [7:0]   hTotal;
    logic [6:0]   vTotal;
    logic [6:0]   vDisp;
    logic [6:0]   vSync;
    logic [7:0]   modeCtl;
    logic [6:0]   curStart;
    logic [4:0]   curEnd;
    logic [13:0]  curPos;
    logic [13:0]  updAddr;
    logic         updReady;
    upd_state_t   upd;
    logic         phase;
    logic [4:0]   fieldCnt;
    logic         curDly;
    refresh_out_t out;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } vr_state_t;

endpackage : video_refresh_pkg

// [video_refresh_addr_cursor.sv]
`timescale 1ns/1ps
`include "video_refresh_consts.svh"
module video_refresh_addr_cursor
  import video_refresh_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic              pslverr,
  output logic [31:0]       prdata,
  input  wire scan_in_t     scanIn,
  output refresh_out_t      refreshOut
);

  // ========================================================
  // Decode helpers
  function automatic logic isMapped(input logic [7:0] a);
    logic [4:0] i;
    i = a[6:2];
    isMapped = 1'b0;
    if (a[7] == 1'b0 && a[1:0] == 2'h0) begin
      case (i)
        `IDX_HTOTAL, `IDX_VTOTAL, `IDX_VDISP, `IDX_VSYNC, `IDX_MODE,
        `IDX_CURSTART, `IDX_CUREND, `IDX_CURPOS_HI, `IDX_CURPOS_LO,
        `IDX_UPD_HI, `IDX_UPD_LO, `IDX_STATUS, `IDX_TRIGGER: isMapped = 1'b1;
        default: isMapped = 1'b0;
      endcase
    end
  endfunction : isMapped

  function automatic logic [13:0] inc14(input logic [13:0] v);
    inc14 = v + 14'h0001;
  endfunction : inc14

  // ========================================================
  // State
  vr_state_t   state_q;
  vr_state_t   state_d;
  logic [13:0] scanSel;
  logic [4:0]  rasterEff;
  logic        transp;
  logic        interleave;
  logic        lineIn;
  logic        posMatch;
  logic        blinkOn;
  logic        cursorRaw;
  logic        apbDone;
  logic        trigger;
  logic [4:0]  idx;

  assign idx        = paddr[6:2];
  assign apbDone    = psel & penable & state_q.pready;
  assign trigger    = apbDone & pwrite & !state_q.pslverr & (idx == `IDX_TRIGGER);
  assign transp     = state_q.modeCtl[`MC_TRANSP];
  assign interleave = state_q.modeCtl[`MC_INTERLEAVE];
  assign scanSel    = state_q.modeCtl[`MC_ROWCOL] ?
                      {scanIn.scanRow, scanIn.scanColumn} :
                      scanIn.scanLinear;
  assign rasterEff  = (state_q.modeCtl[`MC_VIDEO] & state_q.modeCtl[`MC_ILACE]) ?
                      {scanIn.rasterLine[3:0], state_q.out.oddField} :
                      scanIn.rasterLine;
  assign lineIn     = (rasterEff >= state_q.curStart[4:0]) &&
                      (rasterEff <= state_q.curEnd);
  assign posMatch   = (scanSel == state_q.curPos);

  always_comb begin
    case (state_q.curStart[`CS_MODE_HI:`CS_MODE_LO])
      `CMODE_STEADY:  blinkOn = 1'b1;
      `CMODE_OFF:     blinkOn = 1'b0;
      `CMODE_BLINK16: blinkOn = state_q.fieldCnt[`BLINK16_BIT];
      default:        blinkOn = state_q.fieldCnt[`BLINK32_BIT];
    endcase
  end

  assign cursorRaw = blinkOn & lineIn & posMatch;

  // ========================================================
  // Next state
  always_comb begin
    state_d         = state_q;
    state_d.pready  = 1'b0;
    state_d.pslverr = 1'b0;
    state_d.phase   = ~state_q.phase;

    // APB access phase: answer one cycle after the first access cycle
    if (psel && penable && !state_q.pready) begin
      state_d.pready  = 1'b1;
      state_d.pslverr = !isMapped(paddr);
      state_d.prdata  = 32'h0000_0000;
      if (!pwrite) begin
        case (idx)
          `IDX_CURPOS_HI: state_d.prdata[5:0] = state_q.curPos[13:8];
          `IDX_CURPOS_LO: state_d.prdata[7:0] = state_q.curPos[7:0];
          `IDX_STATUS: begin
            state_d.prdata[`ST_READY]    = state_q.updReady;
            state_d.prdata[`ST_VRETRACE] = scanIn.vRetrace;
          end
          default: state_d.prdata = 32'h0000_0000;
        endcase
      end
    end

    if (apbDone && pwrite && !state_q.pslverr) begin
      case (idx)
        `IDX_HTOTAL:    state_d.hTotal          = pwdata[7:0];
        `IDX_VTOTAL:    state_d.vTotal          = pwdata[6:0];
        `IDX_VDISP:     state_d.vDisp           = pwdata[6:0];
        `IDX_VSYNC:     state_d.vSync           = pwdata[6:0];
        `IDX_MODE:      state_d.modeCtl         = pwdata[7:0];
        `IDX_CURSTART:  state_d.curStart        = pwdata[6:0];
        `IDX_CUREND:    state_d.curEnd          = pwdata[4:0];
        `IDX_CURPOS_HI: state_d.curPos[13:8]    = pwdata[5:0];
        `IDX_CURPOS_LO: state_d.curPos[7:0]     = pwdata[7:0];
        `IDX_UPD_HI:    state_d.updAddr[13:8]   = pwdata[5:0];
        `IDX_UPD_LO:    state_d.updAddr[7:0]    = pwdata[7:0];
        default:        state_d.hTotal          = state_q.hTotal;
      endcase
    end

    // Update sequencer, started only by writes to the trigger register
    case (state_q.upd)
      UPD_IDLE: begin
        if (trigger && transp) begin
          state_d.updReady = 1'b0;
          state_d.upd      = UPD_WAIT;
        end
      end
      UPD_WAIT: begin
        if (interleave) begin
          if (state_d.phase == 1'b0) begin
            state_d.updReady = 1'b1;
            state_d.updAddr  = inc14(state_q.updAddr);
            state_d.upd      = UPD_IDLE;
          end
        end else if (scanIn.retrace) begin
          state_d.upd = UPD_DRIVE;
        end
      end
      UPD_DRIVE: begin
        state_d.updReady = 1'b1;
        state_d.updAddr  = inc14(state_q.updAddr);
        state_d.upd      = UPD_IDLE;
      end
      default: state_d.upd = UPD_IDLE;
    endcase

    // Field parity and blink counter
    if (scanIn.fieldStart) begin
      state_d.fieldCnt     = state_q.fieldCnt + 5'h01;
      state_d.out.oddField = state_q.modeCtl[`MC_ILACE] ?
                             ~state_q.out.oddField : 1'b0;
    end

    // Refresh address and strobe
    state_d.out.phi1      = (state_d.phase == 1'b0);
    state_d.out.updStrobe = (state_d.upd == UPD_DRIVE);
    state_d.out.rasterAddr = rasterEff;
    if (!transp) begin
      state_d.out.refreshAddr = scanSel;
    end else if (interleave) begin
      state_d.out.refreshAddr = state_d.out.phi1 ?
                                state_q.updAddr : scanSel;
    end else begin
      state_d.out.refreshAddr = state_d.out.updStrobe ?
                                state_q.updAddr : scanSel;
    end
    state_d.out.sharedPin = (transp && state_q.modeCtl[`MC_STROBE]) ?
                            state_d.out.updStrobe : rasterEff[4];

    // Cursor, optionally one character late
    if (scanIn.charTick) begin
      state_d.curDly     = cursorRaw;
      state_d.out.cursor = state_q.modeCtl[`MC_CURSKEW] ?
                           state_q.curDly : cursorRaw;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q         <= '0;
      state_q.modeCtl <= `MC_RESET;
      state_q.upd     <= UPD_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign pready     = state_q.pready;
  assign pslverr    = state_q.pslverr;
  assign prdata     = state_q.prdata;
  assign refreshOut = state_q.out;

  // ========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_strobe_single: assert property (
    refreshOut.updStrobe |=> !refreshOut.updStrobe && state_q.updReady)
    else $error("update strobe longer than one cycle or no ready");

  a_strobe_addr: assert property (
    refreshOut.updStrobe |-> refreshOut.refreshAddr == state_q.updAddr && transp && !interleave)
    else $error("strobe without update address");

  a_addr_advance: assert property (
    state_q.upd == UPD_DRIVE |=> state_q.updAddr == inc14($past(state_q.updAddr)))
    else $error("update address did not advance");

  a_ready_clear: assert property (
    trigger && transp && state_q.upd == UPD_IDLE |=> !state_q.updReady)
    else $error("ready not cleared by trigger");

  a_shared_scan: assert property (
    !transp && $stable(state_q.modeCtl) |=> refreshOut.refreshAddr == $past(scanSel))
    else $error("shared mode address not from scan counter");

  a_interleave_ph: assert property (
    transp && interleave && $stable(state_q.modeCtl) && state_q.upd != UPD_WAIT
      |=> refreshOut.refreshAddr == ($past(state_q.phase) ? $past(state_q.updAddr) :
                                     $past(scanSel)))
    else $error("interleave address phase wrong");

  a_pin_raster: assert property (
    !state_q.modeCtl[`MC_STROBE] && $stable(state_q.modeCtl)
      |=> refreshOut.sharedPin == $past(rasterEff[4]))
    else $error("shared pin not raster bit four");

  a_cursor_cause: assert property (
    scanIn.charTick && !state_q.modeCtl[`MC_CURSKEW] |=> refreshOut.cursor == $past(cursorRaw))
    else $error("cursor output does not follow match");

  a_field_plain: assert property (
    scanIn.fieldStart && !state_q.modeCtl[`MC_ILACE] |=> !refreshOut.oddField)
    else $error("odd field seen in non-interlace");

  a_field_toggle: assert property (
    scanIn.fieldStart && state_q.modeCtl[`MC_ILACE]
      |=> refreshOut.oddField != $past(refreshOut.oddField))
    else $error("field parity did not alternate");

  a_blink_off: assert property (
    scanIn.charTick && state_q.curStart[`CS_MODE_HI:`CS_MODE_LO] == `CMODE_OFF
      |=> !state_q.curDly)
    else $error("cursor not suppressed in off mode");

  a_cursor_skew: assert property (
    scanIn.charTick && state_q.modeCtl[`MC_CURSKEW]
      |=> refreshOut.cursor == $past(state_q.curDly))
    else $error("skewed cursor not one character late");

  a_rowcol_addr: assert property (
    !transp && state_q.modeCtl[`MC_ROWCOL] && $stable(state_q.modeCtl)
      |=> refreshOut.refreshAddr == {$past(scanIn.scanRow), $past(scanIn.scanColumn)})
    else $error("row and column address layout wrong");

  a_ilv_done: assert property (
    state_q.upd == UPD_WAIT && interleave && state_q.phase
      |=> state_q.updReady && state_q.upd == UPD_IDLE)
    else $error("interleaved update not done in phase one");

  a_trig_ignored: assert property (
    trigger && !transp && state_q.upd == UPD_IDLE |=> state_q.upd == UPD_IDLE)
    else $error("trigger taken in shared mode");

  a_pin_strobe: assert property (
    transp && state_q.modeCtl[`MC_STROBE] && $stable(state_q.modeCtl)
      |=> refreshOut.sharedPin == refreshOut.updStrobe)
    else $error("shared pin not update strobe");

  a_apb_answer: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one cycle");

  c_retrace_upd: cover property (refreshOut.updStrobe);
  c_ilv_upd:     cover property (state_q.upd == UPD_WAIT && interleave ##1 state_q.updReady);
  c_cursor_on:   cover property (refreshOut.cursor);
  c_bad_addr:    cover property (pready && pslverr);
  c_skew_cursor: cover property (state_q.modeCtl[`MC_CURSKEW] && refreshOut.cursor);

endmodule : video_refresh_addr_cursor

// [scan_source_model.sv]
`timescale 1ns/1ps
module scan_source_model
  import video_refresh_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         retraceOn,
  input  wire logic         fieldPulse,
  input  wire logic [4:0]   lineIn,
  input  wire refresh_out_t refreshOut,
  output scan_in_t          scanIn,
  output logic [13:0]       strobeAddr,
  output logic              strobePin,
  output logic [7:0]        strobeCount
);
  // ======
  // Scan timing chain, held at one character
  localparam logic [13:0] POS = 14'h0123;
  logic tick_q;
  logic field_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_q  <= 1'b0;
      field_q <= 1'b0;
    end else begin
      tick_q  <= ~tick_q;
      field_q <= fieldPulse;
    end
  end
  always_comb begin
    scanIn.scanLinear = POS;
    scanIn.scanColumn = 8'(POS % 14'h0050);
    scanIn.scanRow    = 6'(POS / 14'h0050);
    scanIn.rasterLine = lineIn;
    scanIn.charTick   = tick_q;
    scanIn.fieldStart = field_q;
    scanIn.retrace    = retraceOn;
    scanIn.vRetrace   = retraceOn;
  end
  // ======
  // External update latch, captures address at the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strobeAddr  <= 14'h0000;
      strobePin   <= 1'b0;
      strobeCount <= 8'h00;
    end else if (refreshOut.updStrobe) begin
      strobeAddr  <= refreshOut.refreshAddr;
      strobePin   <= refreshOut.sharedPin;
      strobeCount <= strobeCount + 8'h01;
    end
  end
endmodule : scan_source_model

// [tb.sv]
`timescale 1ns/1ps
`include "video_refresh_consts.svh"
module tb
  import video_refresh_pkg::*;
;
  logic         sys_clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rdata;
  scan_in_t     scanIn;
  refresh_out_t refreshOut;
  logic         retraceOn, fieldPulse, strobePin, ph;
  logic [4:0]   lineIn;
  logic [13:0]  strobeAddr;
  logic [7:0]   strobeCount;
  int           n_fail, cmp_count, cyc;
  logic [7:0]   bad [3] = '{8'h04, 8'h21, 8'h80};
  logic [7:0]   cs [4] = '{8'h02, 8'h22, 8'h02, 8'h02};
  logic [7:0]   lo [4] = '{8'h23, 8'h23, 8'h24, 8'h23};
  logic [4:0]   ln [4] = '{5'h05, 5'h03, 5'h03, 5'h04};
  logic         ex [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

  video_refresh_addr_cursor dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .scanIn(scanIn),
    .refreshOut(refreshOut));
  scan_source_model far (.sys_clk(sys_clk), .rst(rst), .retraceOn(retraceOn),
    .fieldPulse(fieldPulse), .lineIn(lineIn), .refreshOut(refreshOut),
    .scanIn(scanIn), .strobeAddr(strobeAddr), .strobePin(strobePin),
    .strobeCount(strobeCount));

  // ======
  // Clock and timeout
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end

  // ======
  // Helpers
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [4:0] i, input logic [31:0] d);
    apb(1'b1, {1'b0, i, 2'b00}, d);
  endtask : wr
  task automatic rd(input logic [4:0] i);
    apb(1'b0, {1'b0, i, 2'b00}, 32'h0);
  endtask : rd
  task automatic settle;
    repeat (6) @(posedge sys_clk);
  endtask : settle
  task automatic pulse;
    @(posedge sys_clk);
    fieldPulse <= 1'b1;
    @(posedge sys_clk);
    fieldPulse <= 1'b0;
    settle();
  endtask : pulse

  // ======
  // Test sequence
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    {retraceOn, fieldPulse, lineIn, n_fail, cmp_count, cyc} = '0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`IDX_STATUS);
    chk("status", rdata, 32'h0);
    wr(`IDX_CURPOS_HI, 32'hFF);
    rd(`IDX_CURPOS_HI);
    chk("curHi", rdata, 32'h3F);
    rd(`IDX_MODE);
    chk("modeErr", rerr, 1'b0);
    foreach (bad[i]) begin
      apb(1'b0, bad[i], 32'h0);
      chk("unmapped", rerr, 1'b1);
    end
    wr(`IDX_MODE, 32'h00);
    settle();
    chk("binAddr", refreshOut.refreshAddr, scanIn.scanLinear);
    wr(`IDX_MODE, 32'h04);
    settle();
    chk("rcAddr", refreshOut.refreshAddr, {scanIn.scanRow, scanIn.scanColumn});
    lineIn <= 5'h13;
    wr(`IDX_MODE, 32'h00);
    settle();
    chk("raster", refreshOut.rasterAddr, 5'h13);
    chk("pinRa4", refreshOut.sharedPin, 1'b1);
    wr(`IDX_HTOTAL, 32'h63);
    wr(`IDX_VTOTAL, 32'h0B);
    wr(`IDX_VDISP, 32'h08);
    wr(`IDX_VSYNC, 32'h08);
    wr(`IDX_MODE, 32'h00);
    pulse();
    chk("oddNi", refreshOut.oddField, 1'b0);
    lineIn <= 5'h05;
    wr(`IDX_MODE, 32'h01);
    pulse();
    chk("oddIs", refreshOut.oddField, 1'b1);
    chk("rasterIs", refreshOut.rasterAddr, 5'h05);
    pulse();
    chk("evenIs", refreshOut.oddField, 1'b0);
    wr(`IDX_MODE, 32'h03);
    settle();
    chk("rasterEven", refreshOut.rasterAddr, 5'h0A);
    pulse();
    chk("rasterOdd", refreshOut.rasterAddr, 5'h0B);
    wr(`IDX_MODE, 32'h02);
    pulse();
    chk("oddX0", refreshOut.oddField, 1'b0);
    chk("rasterX0", refreshOut.rasterAddr, 5'h05);
    wr(`IDX_MODE, 32'h48);
    wr(`IDX_UPD_HI, 32'h01);
    wr(`IDX_UPD_LO, 32'h23);
    wr(`IDX_TRIGGER, 32'h0);
    settle();
    chk("noRetrace", strobeCount, 8'h00);
    retraceOn <= 1'b1;
    while (strobeCount !== 8'h01) @(posedge sys_clk);
    chk("updAddr", strobeAddr, 14'h0123);
    chk("strobePin", strobePin, 1'b1);
    rd(`IDX_STATUS);
    chk("ready", rdata, 32'hA0);
    retraceOn <= 1'b0;
    wr(`IDX_TRIGGER, 32'h0);
    rd(`IDX_STATUS);
    chk("readyClr", rdata, 32'h00);
    retraceOn <= 1'b1;
    while (strobeCount !== 8'h02) @(posedge sys_clk);
    chk("updNext", strobeAddr, 14'h0124);
    wr(`IDX_MODE, 32'h00);
    wr(`IDX_TRIGGER, 32'h0);
    settle();
    chk("sharedIgn", strobeCount, 8'h02);
    retraceOn <= 1'b0;
    wr(`IDX_MODE, 32'h88);
    settle();
    ph = refreshOut.phi1;
    repeat (4) begin
      @(posedge sys_clk);
      chk("phi1", refreshOut.phi1, !ph);
      ph = refreshOut.phi1;
      chk("ilvAddr", refreshOut.refreshAddr,
          refreshOut.phi1 ? 14'h0125 : scanIn.scanLinear);
    end
    wr(`IDX_TRIGGER, 32'h0);
    rd(`IDX_STATUS);
    chk("ilvReady", rdata, 32'h80);
    repeat (2) begin
      @(posedge sys_clk);
      chk("ilvNext", refreshOut.refreshAddr,
          refreshOut.phi1 ? 14'h0126 : scanIn.scanLinear);
    end
    wr(`IDX_MODE, 32'h20);
    wr(`IDX_CURPOS_HI, 32'h01);
    wr(`IDX_CUREND, 32'h04);
    foreach (cs[i]) begin
      wr(`IDX_CURSTART, cs[i]);
      wr(`IDX_CURPOS_LO, lo[i]);
      lineIn <= ln[i];
      settle();
      chk("cursor", refreshOut.cursor, ex[i]);
    end
    wr(`IDX_CURSTART, 32'h42);
    settle();
    chk("blink16Off", refreshOut.cursor, 1'b0);
    repeat (4) pulse();
    chk("blink16On", refreshOut.cursor, 1'b1);
    wr(`IDX_CURSTART, 32'h62);
    settle();
    chk("blink32Off", refreshOut.cursor, 1'b0);
    repeat (8) pulse();
    chk("blink32On", refreshOut.cursor, 1'b1);
    wr(`IDX_MODE, 32'h00);
    settle();
    chk("cursorDirect", refreshOut.cursor, 1'b1);
    test_done();
  end
endmodule : tb
